/* File: inc/scr_defines.svh */
`ifndef SCR_DEFINES_SVH
`define SCR_DEFINES_SVH
// register addresses (7-bit)
`define SCR_ADDR_CFG_LEGACY   7'h12
`define SCR_ADDR_RES_SEL      7'h36
`define SCR_ADDR_SOFT_RST     7'h3a
`define SCR_ADDR_SLEEP        7'h3b
`define SCR_ADDR_LIFT_THR     7'h3d
`define SCR_ADDR_REV_CMPL     7'h3e
`define SCR_ADDR_PART_CMPL    7'h3f
`define SCR_ADDR_BURST        7'h42
// command keys
`define SCR_KEY_SOFT_RST      8'h5a
`define SCR_KEY_SLEEP         8'he7
// reset values
`define SCR_RST_RES_SEL       8'h04
`define SCR_RST_LIFT_THR      8'h56
`define SCR_RST_CFG_LEGACY    8'h00
// field positions
`define SCR_RES_OVR_BIT       4
`define SCR_RES_CODE_HI       3
`define SCR_RES_CODE_LO       1
`define SCR_LEGACY_RES_BIT    4
// lift threshold scale: threshold * 32 = shift by 5
`define SCR_LIFT_SHIFT        5
// burst length in bytes and bytes after which motion clears
`define SCR_BURST_LEN         8
`define SCR_BURST_CLR_AFTER   3
`endif

/* File: inc/scr_pkg.sv */
package scr_pkg;
    // resolution in counts per inch
    typedef enum logic [2:0] {
        SCR_CPI_NONE = 3'h0,
        SCR_CPI_400  = 3'h1,
        SCR_CPI_800  = 3'h2,
        SCR_CPI_1200 = 3'h3,
        SCR_CPI_1600 = 3'h4,
        SCR_CPI_2000 = 3'h5
    } scr_cpi_t;
    // serial transaction phases, one-hot
    typedef enum logic [3:0] {
        SCR_ST_ADDR  = 4'h1,
        SCR_ST_WDATA = 4'h2,
        SCR_ST_RDATA = 4'h4,
        SCR_ST_BURST = 4'h8
    } scr_state_t;
endpackage : scr_pkg

/* File: inc/scr_byte_if.sv */
`timescale 1ns/1ps
// byte stream between serial shifter and register core
interface scr_byte_if;
    logic       rx_valid;   // one-cycle pulse, byte received
    logic [7:0] rx_byte;    // received byte
    logic       first;      // received byte is first of frame
    logic [7:0] tx_byte;    // byte to shift out next
    logic       tx_load;    // pulse: start of a byte slot to load
    logic       frame;      // chip select active (synced)
    modport shifter (output rx_valid, rx_byte, first, tx_load, frame, input tx_byte);
    modport core    (input rx_valid, rx_byte, first, tx_load, frame, output tx_byte);
endinterface : scr_byte_if

/* File: rtl/scr_serial_shift.sv */
`timescale 1ns/1ps
// samples the four-wire serial port (mode 3) and moves whole bytes
module scr_serial_shift (
    input  wire logic clk_sys,      // system clock
    input  wire logic srst,         // sync reset, active high
    input  wire logic chip_select_n,// chip select pin, active low
    input  wire logic sclk,         // serial clock pin
    input  wire logic mosi,         // serial data in pin
    output logic      miso,         // serial data out
    output logic      miso_oe_n,    // miso enable, low while driving
    scr_byte_if.shifter bi          // byte side
);
    typedef struct packed {
        logic [1:0] cs_s;   // chip select sync
        logic [1:0] ck_s;   // clock sync
        logic [1:0] di_s;   // data sync
        logic       ck_p;   // previous synced clock
        logic [2:0] cnt;    // bit counter
        logic [7:0] sh_in;  // receive shift
        logic [7:0] sh_out; // transmit shift
        logic       first;  // next byte is first of frame
        logic       rxv;    // byte received pulse
        logic [7:0] rxb;    // byte received
        logic       rxf;    // that byte was first
        logic       ld;     // load pulse
        logic       ld2;    // load pulse delayed, core tx now registered
        logic       so;     // miso flop
        logic       oe_n;   // miso enable flop
    } scr_shift_st_t;
    scr_shift_st_t s_q, s_d;

    // edge detection only looks at second sync stage
    always_comb begin
        s_d      = s_q;
        s_d.cs_s = {s_q.cs_s[0], chip_select_n};
        s_d.ck_s = {s_q.ck_s[0], sclk};
        s_d.di_s = {s_q.di_s[0], mosi};
        s_d.ck_p = s_q.ck_s[1];
        s_d.rxv  = 1'b0;
        s_d.ld   = 1'b0;
        s_d.ld2  = s_q.ld;
        s_d.oe_n = s_q.cs_s[1];
        if (s_q.cs_s[1]) begin // deselected: frame abandoned
            s_d.cnt   = 3'h0;
            s_d.first = 1'b1;
        end else if (s_q.ck_s[1] && !s_q.ck_p) begin // rising: sample
            s_d.sh_in = {s_q.sh_in[6:0], s_q.di_s[1]};
            s_d.cnt   = s_q.cnt + 3'h1;
            if (s_q.cnt == 3'h7) begin
                s_d.rxv   = 1'b1;
                s_d.rxb   = {s_q.sh_in[6:0], s_q.di_s[1]};
                s_d.rxf   = s_q.first;
                s_d.first = 1'b0;
                s_d.ld    = 1'b1;
            end
        end else if (!s_q.ck_s[1] && s_q.ck_p) begin // falling: shift out
            s_d.so     = s_q.sh_out[7];
            s_d.sh_out = {s_q.sh_out[6:0], 1'b0};
        end
        // core registers tx_byte one cycle after rx_valid, so load a cycle later
        if (s_q.ld2) begin
            s_d.sh_out = bi.tx_byte;
        end
        if (srst) begin
            s_d = '0;
            s_d.cs_s  = 2'h3;
            s_d.ck_s  = 2'h3;
            s_d.ck_p  = 1'b1;
            s_d.first = 1'b1;
            s_d.oe_n  = 1'b1;
        end
    end

    // single state register
    always_ff @(posedge clk_sys) begin
        s_q <= s_d;
    end

    assign bi.rx_valid = s_q.rxv;
    assign bi.rx_byte  = s_q.rxb;
    assign bi.first    = s_q.rxf;
    assign bi.tx_load  = s_q.ld;
    assign bi.frame    = !s_q.cs_s[1];
    assign miso        = s_q.so;
    assign miso_oe_n   = s_q.oe_n;
endmodule : scr_serial_shift

/* File: rtl/scr_ctrl_regs.sv */
`timescale 1ns/1ps
`include "scr_defines.svh"
// Summary of operation
// [RULE1] override clear: legacy config register sets resolution
// [RULE2] override set: three-bit code sets resolution
// [RULE3] codes 1..5 map 400..2000 cpi; bit0 zero
// [RULE4] writing 0x5a to 0x3a resets everything
// [RULE5] writing 0xe7 to 0x3b enters shutdown
// [RULE6] host leaves shutdown by soft reset write
// [RULE7] shutter above threshold times 32 suppresses motion; the code only raises lifted, motion bit and deltas are still reported
// [RULE8] threshold bits 7:1, bit0 reserved, default 0x56
// [RULE9] 0x3e, 0x3f read complemented revision, part codes
// [RULE10] read 0x42 streams eight motion report bytes
// [RULE11] motion cleared after first three burst bytes
// [RULE12] host may stop burst after x byte
// [RULE13] chip select release abandons burst
module scr_ctrl_regs #(
    parameter logic [7:0] SILICON_REV = 8'h01, // arbitrary value
    parameter logic [7:0] PART_ID     = 8'h5c  // arbitrary value
) (
    input  wire logic        clk_sys,        // system clock 10 MHz
    input  wire logic        srst,           // sync reset, active high
    input  wire logic        chip_select_n,  // serial chip select, active low
    input  wire logic        sclk,           // serial clock pin
    input  wire logic        mosi,           // serial data in
    output logic             miso,           // serial data out
    output logic             miso_oe_n,      // miso enable, low while driving
    input  wire logic        motion_event,   // navigation core has new motion
    input  wire logic [11:0] delta_x,        // accumulated x displacement
    input  wire logic [11:0] delta_y,        // accumulated y displacement
    input  wire logic [7:0]  surface_quality,// surface quality
    input  wire logic [15:0] shutter,        // current shutter value
    input  wire logic [7:0]  max_pixel,      // maximum pixel value
    output logic             motion_clear,   // pulse: drop accumulated motion
    output logic             lifted,         // surface lifted, shutter above threshold*32
    output scr_pkg::scr_cpi_t cpi_sel,       // effective resolution
    output logic             sleep_mode,     // low-power shutdown
    output logic             chip_reset      // pulse: full chip reset
);
    scr_byte_if bi ();

    scr_serial_shift u_shift (
        .clk_sys       (clk_sys),
        .srst          (srst),
        .chip_select_n (chip_select_n),
        .sclk          (sclk),
        .mosi          (mosi),
        .miso          (miso),
        .miso_oe_n     (miso_oe_n),
        .bi            (bi)
    );

    typedef struct packed {
        scr_pkg::scr_state_t st;    // transaction phase
        logic [6:0]  addr;          // latched address
        logic [7:0]  cfg_legacy;    // legacy configuration register
        logic [7:0]  res_sel;       // resolution select register
        logic [7:0]  lift_thr;      // lift threshold register
        logic [2:0]  bidx;          // burst byte index
        logic [7:0]  tx;            // byte for next slot
        logic        mclr;          // motion clear pulse
        logic        lift;          // lifted flag
        scr_pkg::scr_cpi_t cpi;     // effective resolution
        logic        sleep;         // shutdown
        logic        crst;          // chip reset pulse
        logic        mot;           // sticky motion seen
    } scr_core_st_t;
    scr_core_st_t r_q, r_d;

    // register read mux, unmapped reads as zero
    function automatic logic [7:0] rd_reg(input scr_core_st_t r, input logic [6:0] a);
        case (a)
            `SCR_ADDR_CFG_LEGACY: rd_reg = r.cfg_legacy;
            `SCR_ADDR_RES_SEL:    rd_reg = {3'h0, r.res_sel[4:1], 1'b0};
            `SCR_ADDR_LIFT_THR:   rd_reg = {r.lift_thr[7:1], 1'b0};
            `SCR_ADDR_REV_CMPL:   rd_reg = ~SILICON_REV; // RULE9
            `SCR_ADDR_PART_CMPL:  rd_reg = ~PART_ID;     // RULE9
            default:              rd_reg = 8'h00;
        endcase
    endfunction : rd_reg

    // burst byte sequence
    function automatic logic [7:0] burst_byte(input logic [2:0] i, input logic m);
        case (i)
            3'h0:    burst_byte = {m, 7'h00};                     // motion status
            3'h1:    burst_byte = delta_x[7:0];
            3'h2:    burst_byte = delta_y[7:0];
            3'h3:    burst_byte = {delta_x[11:8], delta_y[11:8]}; // xy_disp_high
            3'h4:    burst_byte = surface_quality;
            3'h5:    burst_byte = shutter[15:8];
            3'h6:    burst_byte = shutter[7:0];
            default: burst_byte = max_pixel;
        endcase
    endfunction : burst_byte

    // one combinational pass over the whole state
    always_comb begin
        r_d      = r_q;
        r_d.mclr = 1'b0;
        r_d.crst = 1'b0;
        if (motion_event) begin
            r_d.mot = 1'b1; // set wins over clear below
        end
        // lifted when shutter exceeds threshold*32
        r_d.lift = ({1'b0, shutter} >
                    ({10'h000, r_q.lift_thr[7:1]} << `SCR_LIFT_SHIFT)); // RULE7
        // resolution source
        if (r_q.res_sel[`SCR_RES_OVR_BIT]) begin
            // undefined codes keep the last legal setting
            if (r_q.res_sel[`SCR_RES_CODE_HI:`SCR_RES_CODE_LO] inside {[3'h1:3'h5]}) begin
                r_d.cpi = scr_pkg::scr_cpi_t'(
                    r_q.res_sel[`SCR_RES_CODE_HI:`SCR_RES_CODE_LO]); // RULE2 RULE3
            end
        end else begin
            // legacy bit picks between 400 and 800
            r_d.cpi = r_q.cfg_legacy[`SCR_LEGACY_RES_BIT] ? scr_pkg::SCR_CPI_800
                                                          : scr_pkg::SCR_CPI_400; // RULE1
        end
        if (!bi.frame) begin
            r_d.st = scr_pkg::SCR_ST_ADDR; // RULE13
        end else if (bi.rx_valid) begin
            case (r_q.st)
                scr_pkg::SCR_ST_ADDR: begin
                    r_d.addr = bi.rx_byte[6:0];
                    if (bi.rx_byte[7]) begin
                        r_d.st = scr_pkg::SCR_ST_WDATA;
                    end else if (bi.rx_byte[6:0] == `SCR_ADDR_BURST) begin
                        r_d.st   = scr_pkg::SCR_ST_BURST; // RULE10
                        r_d.bidx = 3'h1;
                        r_d.tx   = burst_byte(3'h0, r_q.mot);
                    end else begin
                        r_d.st = scr_pkg::SCR_ST_RDATA;
                        r_d.tx = rd_reg(r_q, bi.rx_byte[6:0]);
                    end
                end
                scr_pkg::SCR_ST_WDATA: begin
                    r_d.st = scr_pkg::SCR_ST_ADDR;
                    case (r_q.addr)
                        `SCR_ADDR_CFG_LEGACY: r_d.cfg_legacy = bi.rx_byte;
                        `SCR_ADDR_RES_SEL:    r_d.res_sel = {3'h0, bi.rx_byte[4:1], 1'b0}; // RULE3
                        `SCR_ADDR_LIFT_THR:   r_d.lift_thr = {bi.rx_byte[7:1], 1'b0}; // RULE8
                        `SCR_ADDR_SLEEP: begin
                            if (bi.rx_byte == `SCR_KEY_SLEEP) begin
                                r_d.sleep = 1'b1; // RULE5
                            end
                        end
                        default: ;
                    endcase
                end
                scr_pkg::SCR_ST_RDATA: begin
                    r_d.st = scr_pkg::SCR_ST_ADDR;
                    r_d.tx = 8'h00;
                end
                scr_pkg::SCR_ST_BURST: begin
                    // byte index bidx-1 just finished
                    if (r_q.bidx == 3'(`SCR_BURST_CLR_AFTER)) begin
                        r_d.mclr = 1'b1; // RULE11
                        r_d.mot  = motion_event;
                    end
                    r_d.tx   = burst_byte(r_q.bidx, r_q.mot);
                    r_d.bidx = r_q.bidx + 3'h1;
                    if (r_q.bidx == 3'h0) begin
                        r_d.st = scr_pkg::SCR_ST_ADDR; // all eight sent
                        r_d.tx = 8'h00;
                    end
                end
                default: r_d.st = scr_pkg::SCR_ST_ADDR;
            endcase
        end
        // soft reset key: everything back to defaults, also ends shutdown
        if (r_q.st == scr_pkg::SCR_ST_WDATA && bi.rx_valid && bi.frame &&
            r_q.addr == `SCR_ADDR_SOFT_RST && bi.rx_byte == `SCR_KEY_SOFT_RST) begin
            r_d            = '0; // RULE4 RULE6
            r_d.st         = scr_pkg::SCR_ST_ADDR;
            r_d.res_sel    = `SCR_RST_RES_SEL;
            r_d.lift_thr   = `SCR_RST_LIFT_THR; // RULE8
            r_d.cfg_legacy = `SCR_RST_CFG_LEGACY;
            r_d.cpi        = scr_pkg::SCR_CPI_400;
            r_d.crst       = 1'b1;
        end
        if (srst) begin
            r_d            = '0;
            r_d.st         = scr_pkg::SCR_ST_ADDR;
            r_d.res_sel    = `SCR_RST_RES_SEL;
            r_d.lift_thr   = `SCR_RST_LIFT_THR;
            r_d.cfg_legacy = `SCR_RST_CFG_LEGACY;
            r_d.cpi        = scr_pkg::SCR_CPI_400;
        end
    end

    // single state register
    always_ff @(posedge clk_sys) begin
        r_q <= r_d;
    end

    assign bi.tx_byte   = r_q.tx;
    assign motion_clear = r_q.mclr;
    assign lifted       = r_q.lift;
    assign cpi_sel      = r_q.cpi;
    assign sleep_mode   = r_q.sleep;
    assign chip_reset   = r_q.crst;
endmodule : scr_ctrl_regs

/* File: testbench/scr_ctrl_regs_chk.sv */
`timescale 1ns/1ps
// watches the register block pins; one clock domain, so default clocking
module scr_ctrl_regs_chk (
    input wire logic              clk_sys,         // system clock
    input wire logic              srst,            // sync reset
    input wire logic              chip_select_n,   // select, low
    input wire logic              sclk,            // serial clock
    input wire logic              mosi,            // data in
    input wire logic              miso,            // data out
    input wire logic              miso_oe_n,       // low drives
    input wire logic              motion_event,    // new motion
    input wire logic [11:0]       delta_x,         // x motion
    input wire logic [11:0]       delta_y,         // y motion
    input wire logic [7:0]        surface_quality, // quality
    input wire logic [15:0]       shutter,         // shutter
    input wire logic [7:0]        max_pixel,       // max pixel
    input wire logic              motion_clear,    // clear pulse
    input wire logic              lifted,          // lift flag
    input wire scr_pkg::scr_cpi_t cpi_sel,         // resolution
    input wire logic              sleep_mode,      // shutdown
    input wire logic              chip_reset       // reset pulse
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);
    // zero shutter never exceeds a threshold, full shutter always does
    lift_low_a: assert property ((shutter == 16'h0000)[*2] |-> !lifted)
        else $error("lifted with zero shutter");
    lift_high_a: assert property ((shutter == 16'hffff)[*2] |-> lifted)
        else $error("not lifted at full shutter");
    rst_pulse_a: assert property (chip_reset |=> !chip_reset)
        else $error("chip reset longer than one cycle");
    rst_defaults_a: assert property (chip_reset |-> ##[1:3]
        (!sleep_mode && cpi_sel == scr_pkg::SCR_CPI_400))
        else $error("defaults not restored after chip reset");
    // shutdown may only end in the cycle that carries the reset pulse
    sleep_hold_a: assert property (sleep_mode |=> (sleep_mode || chip_reset))
        else $error("shutdown left without reset");
    clr_pulse_a: assert property (motion_clear |=> !motion_clear)
        else $error("motion clear longer than one cycle");
    clr_frame_a: assert property (motion_clear |-> !miso_oe_n)
        else $error("motion clear outside a frame");
    oe_idle_a: assert property (chip_select_n[*4] |-> miso_oe_n)
        else $error("data out driven while deselected");
    cpi_legal_a: assert property (cpi_sel != scr_pkg::SCR_CPI_NONE
        && cpi_sel <= scr_pkg::SCR_CPI_2000)
        else $error("resolution code outside table");
    rel_val_a: assert property ($fell(srst) |-> (cpi_sel == scr_pkg::SCR_CPI_400
        && !sleep_mode && miso_oe_n))
        else $error("wrong state on reset release");
endmodule : scr_ctrl_regs_chk

bind scr_ctrl_regs scr_ctrl_regs_chk u_chk (.clk_sys, .srst, .chip_select_n, .sclk, .mosi,
    .miso, .miso_oe_n, .motion_event, .delta_x, .delta_y, .surface_quality, .shutter,
    .max_pixel, .motion_clear, .lifted, .cpi_sel, .sleep_mode, .chip_reset);

/* File: testbench/scr_host_model.sv */
`timescale 1ns/1ps
// microcontroller side: serial master, mode 3, paced by the system clock
module scr_host_model (
    input  wire logic clk_sys,       // pacing clock
    input  wire logic miso,          // data from device
    input  wire logic miso_oe_n,     // device drives when low
    output logic      chip_select_n, // select, active low
    output logic      sclk,          // serial clock, idle high
    output logic      mosi           // data to device
);
    logic rx_q; // last bit taken from the line
    initial begin
        chip_select_n = 1'b1;
        sclk          = 1'b1;
        mosi          = 1'b0;
        rx_q          = 1'b0;
    end
    // five clocks per half period stays above the four-clock minimum
    task automatic half;
        repeat (5) @(negedge clk_sys);
    endtask : half
    // one byte each way, msb first; taken just before the rising edge
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            half();
            sclk = 1'b0;
            mosi = tx[i];
            half();
            // a released line shows the inverse, so stale data cannot pass
            rx_q  = miso_oe_n ? ~rx_q : miso;
            rx[i] = rx_q;
            sclk  = 1'b1;
        end
    endtask : xfer
    // select then address byte; bit 7 set marks a write
    task automatic start(input logic [7:0] a);
        logic [7:0] nc;
        chip_select_n = 1'b0;
        half();
        xfer(a, nc);
    endtask : start
    // deselect ends any transfer, a burst included
    task automatic stop;
        half();
        chip_select_n = 1'b1;
        mosi = ~mosi;
        repeat (20) @(negedge clk_sys);
    endtask : stop
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] nc;
        start({1'b1, a});
        xfer(d, nc);
        stop();
    endtask : wr
    task automatic rd(input logic [6:0] a, output logic [7:0] d);
        start({1'b0, a});
        xfer(8'h00, d);
        stop();
    endtask : rd
    // burst of n bytes; may stop at any byte after x low
    task automatic burst(input int n, output logic [7:0] b [8]);
        start(8'h42);
        for (int k = 0; k < n; k++) xfer(8'h00, b[k]);
        stop();
    endtask : burst
endmodule : scr_host_model

/* File: testbench/testbench.sv */
`timescale 1ns/1ps
// register block bench: pins change on falling edges, host model on the serial side
module testbench;
    logic clk_sys, srst, chip_select_n, sclk, mosi, miso, miso_oe_n; // control and serial
    logic motion_event, motion_clear, lifted, sleep_mode, chip_reset; // core side flags
    logic [11:0] delta_x, delta_y;                                      // displacement
    logic [7:0]  surface_quality, max_pixel;                            // report bytes
    logic [15:0] shutter;                                               // shutter value
    scr_pkg::scr_cpi_t cpi_sel;                                         // resolution
    int fails;  // mismatches
    int checks; // comparisons
    int n_clr = 0; // motion clear pulses
    int n_rst = 0; // chip reset pulses
    logic [7:0] bb [8]; // burst bytes
    // expected burst bytes 1..7 from the driven core values
    localparam logic [7:0] EXPB [8] = '{8'h00, 8'hab, 8'hc6, 8'h93, 8'h5e, 8'h01, 8'h40, 8'h7f};
    scr_ctrl_regs #(.SILICON_REV(8'h21), .PART_ID(8'h93)) u_scr_ctrl_regs (.clk_sys, .srst,
        .chip_select_n, .sclk, .mosi, .miso, .miso_oe_n, .motion_event, .delta_x, .delta_y,
        .surface_quality, .shutter, .max_pixel, .motion_clear, .lifted, .cpi_sel,
        .sleep_mode, .chip_reset);
    scr_host_model u_scr_host_model (.clk_sys, .miso, .miso_oe_n, .chip_select_n, .sclk, .mosi);
    always #50 clk_sys = ~clk_sys;
    // pulse counters, so short pulses are never missed by a late look
    always @(posedge clk_sys) begin
        n_clr <= n_clr + int'(motion_clear === 1'b1);
        n_rst <= n_rst + int'(chip_reset === 1'b1);
    end
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic rchk(input logic [6:0] a, input logic [7:0] exp);
        logic [7:0] v;
        u_scr_host_model.rd(a, v);
        check($sformatf("reg %h", a), 16'(exp), 16'(v));
    endtask : rchk
    // set shutter, let the one-cycle-late flag settle, compare it
    task automatic lift(input logic [15:0] s, input logic exp);
        shutter = s;
        repeat (3) @(negedge clk_sys);
        check("lifted", 16'(exp), 16'(lifted));
    endtask : lift
    task automatic end_sim;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_sim
    // whole run is near 5400 cycles; the limit leaves ample room
    initial begin
        #3_000_000;
        fails++;
        end_sim();
    end
    initial begin
        {clk_sys, motion_event, fails, checks} = '0;
        srst = 1'b1;
        {delta_x, delta_y, surface_quality, max_pixel} = {12'h9ab, 12'h3c6, 8'h5e, 8'h7f};
        shutter = 16'h0000;
        repeat (3) @(negedge clk_sys);
        srst = 1'b0;
        repeat (3) @(negedge clk_sys);
        rchk(7'h36, 8'h04);
        rchk(7'h3d, 8'h56);
        rchk(7'h3e, ~8'h21);
        rchk(7'h3f, ~8'h93);
        rchk(7'h3c, 8'h00);
        // override set: codes 1..5 each reach the resolution output, bit 0 kept zero
        for (int c = 1; c <= 5; c++) begin
            u_scr_host_model.wr(7'h36, {4'h1, 3'(c), 1'b0});
            check("cpi code", 16'(c), 16'(cpi_sel));
        end
        u_scr_host_model.wr(7'h12, 8'h10);
        check("cpi override", 16'h0005, 16'(cpi_sel));
        rchk(7'h12, 8'h10);
        u_scr_host_model.wr(7'h36, 8'h0a);
        check("cpi legacy hi", 16'(scr_pkg::SCR_CPI_800), 16'(cpi_sel));
        rchk(7'h36, 8'h0a);
        u_scr_host_model.wr(7'h12, 8'h00);
        check("cpi legacy lo", 16'(scr_pkg::SCR_CPI_400), 16'(cpi_sel));
        u_scr_host_model.wr(7'h3d, 8'h14);
        lift(16'h0140, 1'b0);
        lift(16'h0141, 1'b1);
        lift(16'hffff, 1'b1);
        lift(16'h0140, 1'b0);
        // full burst after new motion, then a short one stopped after x low
        motion_event = 1'b1;
        @(negedge clk_sys);
        motion_event = 1'b0;
        u_scr_host_model.burst(8, bb);
        check("motion bit", 16'h0001, 16'(bb[0][7]));
        for (int k = 1; k < 8; k++) check("burst byte", 16'(EXPB[k]), 16'(bb[k]));
        check("clears", 16'h0001, 16'(n_clr));
        u_scr_host_model.burst(2, bb);
        check("short x", 16'h00ab, 16'(bb[1]));
        check("no clear", 16'h0001, 16'(n_clr));
        rchk(7'h3d, 8'h14);
        // shutdown, a wrong key on each command, then reset wakes
        u_scr_host_model.wr(7'h3b, 8'h00);
        check("sleep bad key", 16'h0000, 16'(sleep_mode));
        u_scr_host_model.wr(7'h3b, 8'he7);
        check("sleep", 16'h0001, 16'(sleep_mode));
        u_scr_host_model.wr(7'h3a, 8'h5b);
        check("no reset", 16'h0000, 16'(n_rst));
        u_scr_host_model.wr(7'h3a, 8'h5a);
        check("reset pulses", 16'h0001, 16'(n_rst));
        check("awake", 16'h0000, 16'(sleep_mode));
        check("cpi reset", 16'(scr_pkg::SCR_CPI_400), 16'(cpi_sel));
        rchk(7'h3d, 8'h56);
        rchk(7'h36, 8'h04);
        end_sim();
    end
endmodule : testbench
